// File: hw/word_shifter_map.vh
/*
 * constants for the one-bit word shifter: opcode, shift-operation
 * field layout and flag positions.
 * assumes inclusion by bare name from the shifter design files.
 */
`ifndef WORD_SHIFTER_MAP_VH
`define WORD_SHIFTER_MAP_VH

`define SHF_OPCODE      8'h18
`define SO_OP_HI        15
`define SO_OP_LO        14
`define SO_DBL_BIT      13
`define SO_CLOSED_BIT   12
`define OP_SWAP         2'h0
`define OP_LSL          2'h1
`define OP_LSR          2'h2
`define OP_ASR          2'h3
`define FMT_BRANCH      2'h1
`define FMT_SKIP        2'h2
`define FLAG_C          5
`define FLAG_V          4
`define FLAG_Z          3
`define FLAG_N          2
`define FLAG_P          1
`define FLAG_D          0
`define FLAGS_RST       6'h00
`define WORD_RST        16'h0000

`endif

// File: hw/shift_core.v
/*
 * combinational one-place shift of a word and an extension word.
 * assumes operands are stable for the whole microcycle.
 */
module shift_core
(
    // operands
    input  wire [15:0] a_i,
    input  wire [15:0] ext_i,
    input  wire [1:0]  op_i,
    input  wire        closed_i,
    input  wire        dbl_i,
    input  wire        byte_i,
    input  wire        cin_i,
    input  wire        nstat_i,
    // results
    output reg  [15:0] r_o,
    output reg  [15:0] ext_o,
    output reg         c_o,
    output reg         fill_o
);
`include "word_shifter_map.vh"

    // fill bit entering the vacated end, result per op
    always @*
    begin
        r_o    = a_i;
        ext_o  = ext_i;
        c_o    = 1'b0;
        fill_o = 1'b0;
        case (op_i)
            `OP_SWAP:
            begin
                c_o = byte_i ? a_i[7] : a_i[15];
                if (byte_i)
                    r_o = {a_i[15:8], a_i[3:0], a_i[7:4]};
                else
                    r_o = {a_i[7:0], a_i[15:8]};
            end
            `OP_LSL:
            begin
                c_o = byte_i ? a_i[7] : a_i[15];
                fill_o = closed_i ? c_o : cin_i;
                if (dbl_i)
                begin
                    ext_o = {ext_i[14:0], fill_o};
                    fill_o = ext_i[15];
                end
                if (byte_i)
                    r_o = {a_i[15:8], a_i[6:0], fill_o};
                else
                    r_o = {a_i[14:0], fill_o};
            end
            default:
            begin
                c_o = a_i[0];
                if (closed_i)
                    fill_o = a_i[0];
                else if (op_i == `OP_ASR)
                    fill_o = nstat_i | cin_i;
                else
                    fill_o = cin_i;
                if (dbl_i)
                begin
                    ext_o = {fill_o, ext_i[15:1]};
                    fill_o = ext_i[0];
                end
                if (byte_i)
                    r_o = {a_i[15:8], fill_o, a_i[7:1]};
                else
                    r_o = {fill_o, a_i[15:1]};
            end
        endcase
    end

endmodule

// File: hw/flag_gen.v
/*
 * microcondition flag generation for shift results.
 * assumes carry and overflow inputs are already resolved.
 */
module flag_gen
(
    // inputs
    input  wire [15:0] r_i,
    input  wire        byte_i,
    input  wire        c_i,
    input  wire        v_i,
    // flags c v z n p d
    output wire [5:0]  flags_o
);
`include "word_shifter_map.vh"

    wire sign_w;
    wire zero_w;

    // byte mode tests only the low byte
    assign sign_w = byte_i ? r_i[7] : r_i[15];
    assign zero_w = byte_i ? (r_i[7:0] == 8'h00) : (r_i == 16'h0000);
    assign flags_o = {c_i, v_i, zero_w, sign_w, ~zero_w & ~sign_w, r_i[0]};

endmodule

// File: hw/microcoded_word_shifter.v
/*
 * shift microcommand datapath: one-bit swap/left/right/arith shifts,
 * word or byte, single or double precision, with six flags.
 * assumes the decoder presents opcode, fields and carry-in for one
 * microcycle; results are registered at the end of that cycle.
 */
module microcoded_word_shifter
(
    // clock and reset
    input  wire        clk_i,
    input  wire        resetn_i,
    // microinstruction fields
    input  wire        exec_i,
    input  wire [7:0]  opcode_i,
    input  wire [1:0]  format_i,
    input  wire [15:0] shift_op_i,
    input  wire        byte_mode_i,
    input  wire        fn_ext_shift_i,
    input  wire [1:0]  fn_ext_dir_i,
    input  wire        selected_carry_in_i,
    input  wire        nstat_i,
    // operand
    input  wire [15:0] a_i,
    // extension register preload
    input  wire        ext_load_i,
    input  wire [15:0] ext_load_data_i,
    // results
    output reg  [15:0] dest_o,
    output reg         dest_we_o,
    output reg  [5:0]  flags_o,
    output wire [15:0] extension_reg_o,
    output wire        active_o
);
`include "word_shifter_map.vh"

    reg  [15:0] extension_reg_r;
    reg  [15:0] ext_nxt;
    reg         v_nxt;
    wire        hit_w;
    wire [1:0]  op_w;
    wire        dbl_w;
    wire        closed_w;
    wire [15:0] r_w;
    wire [15:0] ext_sh_w;
    wire        c_w;
    wire        fill_w;
    wire [5:0]  flags_w;
    wire        a_top_w;

    // decode helper: accepted microinstruction formats
    function fmt_ok;
        input [1:0] f;
        begin
            fmt_ok = (f == `FMT_BRANCH) || (f == `FMT_SKIP);
        end
    endfunction

    assign hit_w    = exec_i && (opcode_i == `SHF_OPCODE)
                      && fmt_ok(format_i);
    assign op_w     = shift_op_i[`SO_OP_HI:`SO_OP_LO];
    assign dbl_w    = shift_op_i[`SO_DBL_BIT];
    assign closed_w = shift_op_i[`SO_CLOSED_BIT];
    assign active_o = hit_w;
    assign a_top_w  = byte_mode_i ? a_i[7] : a_i[15];

    // the shift itself; swap ignores precision, xr shifts on a double shift or on fn_ext_shift_i with double clear
    shift_core u_core
    (
        .a_i      (a_i),
        .ext_i    (extension_reg_r),
        .op_i     (op_w),
        .closed_i (closed_w),
        .dbl_i    (dbl_w && (op_w != `OP_SWAP)),
        .byte_i   (byte_mode_i),
        .cin_i    (selected_carry_in_i),
        .nstat_i  (nstat_i),
        .r_o      (r_w),
        .ext_o    (ext_sh_w),
        .c_o      (c_w),
        .fill_o   (fill_w)
    );

    // overflow per shift kind
    always @*
    begin
        v_nxt = 1'b0;
        case (op_w)
            `OP_SWAP, `OP_LSL:
                v_nxt = byte_mode_i ? (a_i[7] ^ a_i[6])
                                    : (a_i[15] ^ a_i[14]);
            default:
                if (closed_w)
                    v_nxt = a_top_w ^ a_i[0];
                else if (op_w == `OP_ASR)
                    v_nxt = a_top_w ^ (nstat_i | selected_carry_in_i);
                else
                    v_nxt = a_top_w ^ selected_carry_in_i;
        endcase
    end

    // flags from result; byte mode uses the low byte
    flag_gen u_flags
    (
        .r_i     (r_w),
        .byte_i  (byte_mode_i),
        .c_i     (c_w),
        .v_i     (v_nxt),
        .flags_o (flags_w)
    );

    // extension next value; double field wins over function field
    always @*
    begin
        ext_nxt = extension_reg_r;
        if (ext_load_i)
            ext_nxt = ext_load_data_i;
        else if (hit_w && dbl_w && op_w != `OP_SWAP)
            ext_nxt = ext_sh_w;
        else if (hit_w && !dbl_w && fn_ext_shift_i)
        begin
            if (fn_ext_dir_i[0])
                ext_nxt = {extension_reg_r[14:0], 1'b0};
            else
                ext_nxt = {1'b0, extension_reg_r[15:1]};
        end
    end

    // result registers; one shift per microcycle, loops are external
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dest_o          <= `WORD_RST;
            dest_we_o       <= 1'b0;
            flags_o         <= `FLAGS_RST;
            extension_reg_r <= `WORD_RST;
        end
        else
        begin
            dest_we_o       <= hit_w;
            extension_reg_r <= ext_nxt;
            if (hit_w)
            begin
                dest_o  <= r_w;
                flags_o <= flags_w;
            end
        end
    end

    assign extension_reg_o = extension_reg_r;

endmodule

// File: sim/word_shifter_assertions.sv
/* port assertions for the one-bit word shifter.
   assumes binding onto the shifter top module, single clock. */
module word_shifter_chk
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        resetn_i,
    // command side
    input wire logic [15:0] shift_op_i,
    input wire logic        byte_mode_i,
    input wire logic        selected_carry_in_i,
    input wire logic [15:0] a_i,
    // result side
    input wire logic        active_o,
    input wire logic        dest_we_o,
    input wire logic [15:0] dest_o,
    input wire logic [5:0]  flags_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire [1:0] op = shift_op_i[15:14];

    property p_we;
        active_o |=> dest_we_o;
    endproperty
    a_we: assert property (p_we) else $error("accepted shift not written");
    property p_idle;
        !active_o |=> !dest_we_o && $stable(dest_o) && $stable(flags_o);
    endproperty
    a_idle: assert property (p_idle) else $error("idle cycle changed result");
    property p_wswap;
        active_o && op == 2'h0 && !byte_mode_i
            |=> dest_o == {$past(a_i[7:0]), $past(a_i[15:8])};
    endproperty
    a_wswap: assert property (p_wswap) else $error("word swap wrong");
    property p_bswap;
        active_o && op == 2'h0 && byte_mode_i
            |=> dest_o[7:0] == {$past(a_i[3:0]), $past(a_i[7:4])};
    endproperty
    a_bswap: assert property (p_bswap) else $error("byte swap wrong");
    property p_upper;
        active_o && byte_mode_i |=> dest_o[15:8] == $past(a_i[15:8]);
    endproperty
    a_upper: assert property (p_upper) else $error("upper byte altered");
    property p_lcarry;
        active_o && !op[1] |=> flags_o[5] ==
            ($past(byte_mode_i) ? $past(a_i[7]) : $past(a_i[15]));
    endproperty
    a_lcarry: assert property (p_lcarry) else $error("left carry wrong");
    property p_rcarry;
        active_o && op[1] |=> flags_o[5] == $past(a_i[0]);
    endproperty
    a_rcarry: assert property (p_rcarry) else $error("right carry wrong");
    property p_zd;
        dest_we_o |-> flags_o[0] == dest_o[0] && flags_o[3] ==
            ($past(byte_mode_i) ? dest_o[7:0] == 8'h00 : dest_o == 16'h0000);
    endproperty
    a_zd: assert property (p_zd) else $error("zero or d flag wrong");
    property p_ofill;
        active_o && op == 2'h1 && shift_op_i[13:12] == 2'h0
            |=> dest_o[0] == $past(selected_carry_in_i);
    endproperty
    a_ofill: assert property (p_ofill) else $error("open left fill wrong");
endmodule

bind microcoded_word_shifter word_shifter_chk u_chk (.*);

// File: sim/shift_decoder_model.sv
/* decoder stand-in: one microinstruction a cycle, mostly shifts,
   as a packed word; assumes the bench slices it onto the shifter. */
module shift_decoder_model
(
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   resetn_i,
    // packed microinstruction
    output logic [65:0] uinst_o
);
    timeunit 1ns;
    timeprecision 1ps;
    integer      seed = 32'h76005a1b;
    logic [95:0] r;
    logic [65:0] w;

    initial uinst_o = 66'h0;
    // multibit shifts are only repeats of single ones
    always @(posedge clk_i)
    begin
        r = {$random(seed), $random(seed), $random(seed)};
        w = r[65:0];
        w[65] = r[70] | r[71];
        w[64:57] = (r[74:72] == 3'h0) ? r[64:57] : 8'h18;
        w[16] = (r[77:75] == 3'h0);
        if (r[80:78] == 3'h0)
            w[32:17] = {r[81], 7'h00, r[82], 7'h00}; // zero and sign corners
        uinst_o <= resetn_i ? w : 66'h0;
    end
endmodule

// File: sim/tb.sv
/* self-checking bench for the word shifter: random commands from the
   decoder model, expected results from a bench function. */
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [65:0] u;
    logic [15:0] dest_o, ext_o, x_r = 16'h0, er_r = 16'h0;
    logic [5:0]  flags_o, ef_r = 6'h0;
    logic        dest_we_o, active_o, acc, pend_r = 1'b0;
    logic [37:0] m;
    // combinational accept expected from the exec, opcode and format fields
    wire         exp_act = u[65] && u[64:57] == 8'h18 && u[56] != u[55];
    int          fails = 0, total_checks = 0, cyc = 0;

    // {ext, c v z n p d, result} for one command
    function automatic logic [37:0] model(logic [65:0] q, logic [15:0] x);
        logic [15:0] a, r, nx;
        logic [1:0]  op;
        logic        bm, cl, db, top, fil, inb, c, v, z, n;
        a = q[32:17];
        op = q[54:53];
        db = q[52];
        cl = q[51];
        bm = q[38];
        top = bm ? a[7] : a[15];
        fil = (op == 2'h3) ? (q[33] | q[34]) : q[34];
        c = op[1] ? a[0] : top;
        v = !op[1] ? top ^ (bm ? a[6] : a[14]) : top ^ (cl ? a[0] : fil);
        inb = op[1] ? (db ? x[0] : (cl ? a[0] : fil))
                    : (db ? x[15] : (cl ? top : q[34]));
        case (op)
            2'h0: r = bm ? {a[15:8], a[3:0], a[7:4]} : {a[7:0], a[15:8]};
            2'h1: r = bm ? {a[15:8], a[6:0], inb} : {a[14:0], inb};
            default: r = bm ? {a[15:8], inb, a[7:1]} : {inb, a[15:1]};
        endcase
        nx = x;
        if (db && op != 2'h0)
            nx = op[1] ? {cl ? a[0] : fil, x[15:1]} : {x[14:0], cl ? top : q[34]};
        else if (!db && q[37])
            nx = q[35] ? {x[14:0], 1'b0} : {1'b0, x[15:1]};
        z = bm ? r[7:0] == 8'h00 : r == 16'h0000;
        n = bm ? r[7] : r[15];
        model = {nx, c, v, z, n, !z && !n, r[0], r};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    shift_decoder_model u_dec (.clk_i(clk_i), .resetn_i(resetn_i), .uinst_o(u));

    microcoded_word_shifter DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .exec_i(u[65]),
        .opcode_i(u[64:57]), .format_i(u[56:55]), .shift_op_i(u[54:39]),
        .byte_mode_i(u[38]), .fn_ext_shift_i(u[37]), .fn_ext_dir_i(u[36:35]),
        .selected_carry_in_i(u[34]), .nstat_i(u[33]), .a_i(u[32:17]),
        .ext_load_i(u[16]), .ext_load_data_i(u[15:0]), .dest_o(dest_o),
        .dest_we_o(dest_we_o), .flags_o(flags_o), .extension_reg_o(ext_o),
        .active_o(active_o));

    initial forever #4 clk_i = ~clk_i;

    // expected state; a load wins over a shift in the same cycle
    always @(posedge clk_i)
    begin
        m = model(u, x_r);
        acc = resetn_i && u[65] && u[64:57] == 8'h18 && u[56] != u[55];
        cyc <= cyc + 1;
        pend_r <= acc;
        x_r <= !resetn_i ? 16'h0 : u[16] ? u[15:0] : acc ? m[37:22] : x_r;
        if (acc)
        begin
            ef_r <= m[21:16];
            er_r <= m[15:0];
        end
        if (cyc == 5000)
        begin
            fails++;
            report_and_stop();
        end
    end

    // outputs are settled mid-cycle
    always @(negedge clk_i)
    begin
        if (resetn_i)
        begin
            `CHK(dest_we_o, pend_r)
            `CHK(active_o, exp_act)
            `CHK(dest_o, er_r)
            `CHK(flags_o, ef_r)
            `CHK(ext_o, x_r)
        end
    end

    initial
    begin
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3000) @(posedge clk_i);
        report_and_stop();
    end
endmodule
